// *** core/twmr_buf.sv ***
// Small receive buffer with valid/ready on both sides
module twmr_buf
    import twmr_pkg::*;
#(
    parameter int WIDTH = 8,
    parameter int DEPTH = 2
) (
    // Clock and reset
    input  wire logic             clk_in,
    input  wire logic             rst_in,
    // Fill side
    input  wire logic             in_valid_in,
    output logic                  in_ready_out,
    input  wire logic [WIDTH-1:0] in_data_in,
    // Drain side
    output logic                  out_valid_out,
    input  wire logic             out_ready_in,
    output logic      [WIDTH-1:0] out_data_out
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem_ff [DEPTH];   // Storage words
    logic [AW-1:0]    wptr_ff;          // Next write slot
    logic [AW-1:0]    rptr_ff;          // Oldest word
    logic [CW-1:0]    cnt_ff;           // Words held
    logic             push;
    logic             pop;

    assign push          = in_valid_in && in_ready_out;
    assign pop           = out_valid_out && out_ready_in;
    assign in_ready_out  = (cnt_ff != CW'(DEPTH));
    assign out_valid_out = (cnt_ff != '0);
    assign out_data_out  = mem_ff[rptr_ff];

    // Pointer advance with wrap
    function automatic logic [AW-1:0] wrap_inc(input logic [AW-1:0] p);
        wrap_inc = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
    endfunction

    // Storage write
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            for (int i = 0; i < DEPTH; i++) mem_ff[i] <= TWMR_DATA_RST;
        end else if (push) begin
            mem_ff[wptr_ff] <= in_data_in;
        end
    end

    // Pointers and fill count
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            wptr_ff <= '0;
            rptr_ff <= '0;
            cnt_ff  <= '0;
        end else begin
            if (push) wptr_ff <= wrap_inc(wptr_ff);
            if (pop) rptr_ff <= wrap_inc(rptr_ff);
            if (push && !pop) cnt_ff <= cnt_ff + CW'(1);
            else if (pop && !push) cnt_ff <= cnt_ff - CW'(1);
        end
    end
endmodule // twmr_buf

// *** core/twmr_core.sv ***
// Two-wire master read sequencer with AHB-Lite register slave
// What this block does
// - Open read with a start condition
// - Shift out address then read bit
// - Address nack sets flag, clears ack state
// - Stop plus txi clear: flush, stop, clear
// - Shift in byte then raise receive status
// - Nack final byte, ack all others
// - Repeat reception while bytes remain
// - After final nack set missing-ack flag
// - Software sets stop, controller sends stop
// - Ten-bit read: write, address, restart, read
// - First ten-bit byte carries two top bits
// - Last first-byte bit gives direction
// - Shift register hidden from register space
// - Block data writes during slave receive
//
// Design decision made here: the AHB-Lite interface to the registers.
module twmr_core
    import twmr_pkg::*;
#(
    parameter int QTR_CYCLES = TWMR_QTR_CYC,
    parameter int FIFO_DEPTH = 2
) (
    // Clock and reset
    input  wire logic        clk_in,
    input  wire logic        rst_in,
    // AHB-Lite slave
    input  wire logic        hsel_in,
    input  wire logic [31:0] haddr_in,
    input  wire logic [1:0]  htrans_in,
    input  wire logic        hwrite_in,
    input  wire logic [2:0]  hsize_in,
    input  wire logic [31:0] hwdata_in,
    input  wire logic        hready_in,
    output logic      [31:0] hrdata_out,
    output logic             hreadyout_out,
    output logic             hresp_out,
    // Slave-mode receive in progress, same clock
    input  wire logic        slave_rx_busy_in,
    // Serial clock pin, open drain
    input  wire logic        scl_in,
    output logic             scl_out,
    output logic             scl_oe_out,
    // Serial data pin, open drain
    input  wire logic        sda_in,
    output logic             sda_out,
    output logic             sda_oe_out
);
    twmr_state_t st_ff;          // Sequencer state
    logic [1:0]  ph_ff;          // Quarter phase of a bit
    logic [2:0]  cnt_ff;         // Bit counter
    logic [1:0]  seq_ff;         // Address byte index
    logic [7:0]  shift_ff;       // Internal shift register, not mapped
    logic        samp_ff;        // Data level sampled at end of high phase
    logic        last_ff;        // Current byte answered with nack
    logic [1:0]  scl_sync_ff;    // Clock pin synchroniser
    logic [1:0]  sda_sync_ff;    // Data pin synchroniser
    logic [15:0] div_ff;         // Quarter-phase divider
    logic        scl_oe_ff;      // Pull clock low
    logic        sda_oe_ff;      // Pull data low
    logic        nxt_scl_oe;
    logic        nxt_sda_oe;
    logic        start_ff, stop_ff, nak_ff, txi_ff, ten_ff;   // Control bits
    logic [9:0]  saddr_ff;       // Slave address
    logic        miss_ff;        // Missing-acknowledge flag
    logic        ack_state_ff;   // Address acknowledged
    logic        tx_full_ff;     // Transmit byte held
    logic [7:0]  tx_data_ff;     // Transmit byte
    logic        dp_wr_ff;       // Write data phase pending
    logic [2:0]  dp_sel_ff;      // Register selected for write
    logic [31:0] hrdata_ff;      // Read data
    logic        fifo_in_ready, fifo_out_valid;
    logic [7:0]  fifo_out_data;
    logic        scl_s, sda_s, tick, stretch, push_wait, adv, bit_end;
    logic        ap_valid, pop, w1c_miss;
    logic        ev_start, ev_addr_nack, ev_final_nack, ev_go_stop, ev_stop_done, ev_push;

    // Register select decode: 1 data, 2 ctrl, 3 status, 4 address, 0 none
    function automatic logic [2:0] reg_sel(input logic [31:0] a);
        case (a[11:0])
            TWMR_DATA_OFS:  reg_sel = 3'h1;
            TWMR_CTRL_OFS:  reg_sel = 3'h2;
            TWMR_STAT_OFS:  reg_sel = 3'h3;
            TWMR_SADDR_OFS: reg_sel = 3'h4;
            default:        reg_sel = 3'h0;
        endcase
    endfunction

    // Address byte by index; direction in bit 0 of bytes 0 and 2
    function automatic logic [7:0] addr_byte(input logic [1:0] s, input logic ten, input logic [9:0] a);
        case (s)
            2'h0:    addr_byte = ten ? {TWMR_TEN_PREFIX, a[9:8], TWMR_DIR_WR} : {a[6:0], TWMR_DIR_RD};
            2'h1:    addr_byte = a[7:0];
            default: addr_byte = {TWMR_TEN_PREFIX, a[9:8], TWMR_DIR_RD};
        endcase
    endfunction

    // Pin synchronisers; only the second stage is read
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            scl_sync_ff <= 2'h3;
            sda_sync_ff <= 2'h3;
        end else begin
            scl_sync_ff <= {scl_sync_ff[0], scl_in};
            sda_sync_ff <= {sda_sync_ff[0], sda_in};
        end
    end
    assign scl_s = scl_sync_ff[1];
    assign sda_s = sda_sync_ff[1];

    // Quarter-phase enable divider
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) div_ff <= 16'h0000;
        else div_ff <= tick ? 16'h0000 : div_ff + 16'h0001;
    end
    assign tick = (div_ff == 16'(QTR_CYCLES - 1));

    // Advance holds while a slave stretches the clock or the buffer is full
    assign stretch   = (ph_ff == 2'h1) && !scl_s;
    assign push_wait = (st_ff == ST_RX) && (ph_ff == 2'h3) && (cnt_ff == 3'h7) && !fifo_in_ready;
    assign adv       = tick && !stretch && !push_wait;
    assign bit_end   = adv && (ph_ff == 2'h3);

    // Sequence events
    assign ev_start      = (st_ff == ST_IDLE) && start_ff && tick;
    assign ev_addr_nack  = (st_ff == ST_AACK) && bit_end && samp_ff;
    assign ev_final_nack = (st_ff == ST_MACK) && bit_end && last_ff;
    assign ev_go_stop    = (st_ff == ST_HOLD) && tick && stop_ff && !txi_ff;
    assign ev_stop_done  = (st_ff == ST_STOP) && bit_end;
    assign ev_push       = (st_ff == ST_RX) && bit_end && (cnt_ff == 3'h7);

    // Phase counter runs only in bit-timed states
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) ph_ff <= 2'h0;
        else if (st_ff == ST_IDLE || st_ff == ST_HOLD) ph_ff <= 2'h0;
        else if (adv) ph_ff <= ph_ff + 2'h1;
    end

    // Data sampled at the end of each clock high phase
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) samp_ff <= 1'b1;
        else if (adv && ph_ff == 2'h2) samp_ff <= sda_s;
    end

    // Main sequencer
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            st_ff    <= ST_IDLE;
            cnt_ff   <= 3'h0;
            seq_ff   <= 2'h0;
            shift_ff <= TWMR_DATA_RST;
            last_ff  <= 1'b0;
        end else begin
            case (st_ff)
                ST_IDLE: begin
                    seq_ff <= 2'h0;
                    if (ev_start) st_ff <= ST_START;
                end
                ST_START: begin
                    if (bit_end) begin
                        shift_ff <= addr_byte(seq_ff, ten_ff, saddr_ff);
                        cnt_ff   <= 3'h0;
                        st_ff    <= ST_ADDR;
                    end
                end
                ST_ADDR: begin
                    // Send MSB first
                    if (bit_end) begin
                        if (cnt_ff == 3'h7) st_ff <= ST_AACK;
                        shift_ff <= {shift_ff[6:0], 1'b0};
                        cnt_ff   <= cnt_ff + 3'h1;
                    end
                end
                ST_AACK: begin
                    if (ev_addr_nack) begin
                        st_ff <= ST_HOLD;
                    end else if (bit_end) begin
                        cnt_ff <= 3'h0;
                        if (seq_ff == 2'h0 && ten_ff) begin
                            // Second ten-bit address byte follows directly
                            seq_ff   <= 2'h1;
                            shift_ff <= addr_byte(2'h1, ten_ff, saddr_ff);
                            st_ff    <= ST_ADDR;
                        end else if (seq_ff == 2'h1) begin
                            // Repeated start, then first byte with read bit
                            seq_ff <= 2'h2;
                            st_ff  <= ST_START;
                        end else begin
                            st_ff <= ST_RX;
                        end
                    end
                end
                ST_RX: begin
                    if (bit_end) begin
                        shift_ff <= {shift_ff[6:0], samp_ff};
                        cnt_ff   <= cnt_ff + 3'h1;
                        if (cnt_ff == 3'h7) begin
                            last_ff <= nak_ff;
                            st_ff   <= ST_MACK;
                        end
                    end
                end
                ST_MACK: begin
                    if (ev_final_nack) st_ff <= ST_HOLD;
                    else if (bit_end) st_ff <= ST_RX;
                end
                ST_HOLD: begin
                    if (ev_go_stop) st_ff <= ST_STOP;
                end
                ST_STOP: begin
                    if (ev_stop_done) st_ff <= ST_IDLE;
                end
                default: st_ff <= ST_IDLE;
            endcase
        end
    end

    // Pin drive per state and phase; low phases 0 and 3 of each bit
    always_comb begin
        nxt_scl_oe = (ph_ff == 2'h0) || (ph_ff == 2'h3);
        nxt_sda_oe = 1'b0;
        case (st_ff)
            ST_IDLE:  nxt_scl_oe = 1'b0;
            ST_START: begin
                nxt_scl_oe = (ph_ff == 2'h3);
                nxt_sda_oe = ph_ff[1];
            end
            ST_ADDR:  nxt_sda_oe = !shift_ff[7];
            ST_AACK:  nxt_sda_oe = 1'b0;
            ST_RX:    nxt_sda_oe = 1'b0;
            ST_MACK:  nxt_sda_oe = !last_ff;
            ST_HOLD: begin
                nxt_scl_oe = 1'b1;
                nxt_sda_oe = 1'b1;
            end
            ST_STOP: begin
                nxt_scl_oe = (ph_ff == 2'h0);
                nxt_sda_oe = !ph_ff[1];
            end
            default:  nxt_scl_oe = 1'b0;
        endcase
    end

    // Registered pin enables
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            scl_oe_ff <= 1'b0;
            sda_oe_ff <= 1'b0;
        end else begin
            scl_oe_ff <= nxt_scl_oe;
            sda_oe_ff <= nxt_sda_oe;
        end
    end
    assign scl_oe_out = scl_oe_ff;
    assign sda_oe_out = sda_oe_ff;
    assign scl_out    = 1'b0;
    assign sda_out    = 1'b0;

    // Receive buffer between shifter and data register
    twmr_buf #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_rxbuf (
        .clk_in        (clk_in),
        .rst_in        (rst_in),
        .in_valid_in   (ev_push),
        .in_ready_out  (fifo_in_ready),
        .in_data_in    ({shift_ff[6:0], samp_ff}),
        .out_valid_out (fifo_out_valid),
        .out_ready_in  (pop),
        .out_data_out  (fifo_out_data)
    );

    // AHB-Lite address phase capture; zero wait states
    assign ap_valid = hsel_in && htrans_in[1] && hready_in;
    assign pop      = ap_valid && !hwrite_in && (reg_sel(haddr_in) == 3'h1) && fifo_out_valid;
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            dp_wr_ff  <= 1'b0;
            dp_sel_ff <= 3'h0;
            hrdata_ff <= 32'h00000000;
        end else begin
            dp_wr_ff  <= ap_valid && hwrite_in;
            dp_sel_ff <= reg_sel(haddr_in);
            if (ap_valid && !hwrite_in) begin
                // Shift register has no address; only buffered bytes read back
                case (reg_sel(haddr_in))
                    3'h1:    hrdata_ff <= {24'h000000, fifo_out_data};
                    3'h2:    hrdata_ff <= {27'h0000000, ten_ff, txi_ff, nak_ff, stop_ff, start_ff};
                    3'h3:    hrdata_ff <= {26'h0000000, !fifo_in_ready, tx_full_ff, st_ff != ST_IDLE,
                                           fifo_out_valid, ack_state_ff, miss_ff};
                    3'h4:    hrdata_ff <= {22'h000000, saddr_ff};
                    default: hrdata_ff <= 32'h00000000;
                endcase
            end
        end
    end
    assign hrdata_out    = hrdata_ff;
    assign hreadyout_out = 1'b1;
    assign hresp_out     = 1'b0;

    // Control bits: software write, hardware self-clear of start, stop and nak
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            {ten_ff, txi_ff, nak_ff, stop_ff, start_ff} <= TWMR_CTRL_RST;
            saddr_ff <= TWMR_SADDR_RST;
        end else if (dp_wr_ff && dp_sel_ff == 3'h2) begin
            start_ff <= hwdata_in[TWMR_CTL_START];
            stop_ff  <= hwdata_in[TWMR_CTL_STOP];
            nak_ff   <= hwdata_in[TWMR_CTL_NAK];
            txi_ff   <= hwdata_in[TWMR_CTL_TXI];
            ten_ff   <= hwdata_in[TWMR_CTL_TEN];
        end else begin
            if (dp_wr_ff && dp_sel_ff == 3'h4) saddr_ff <= hwdata_in[9:0];
            if (ev_start) start_ff <= 1'b0;
            if (ev_stop_done) stop_ff <= 1'b0;
            if (ev_final_nack) nak_ff <= 1'b0;
        end
    end

    // Status flags; a hardware set wins over a software clear
    assign w1c_miss = dp_wr_ff && (dp_sel_ff == 3'h3) && hwdata_in[TWMR_STS_MISS];
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            miss_ff      <= 1'b0;
            ack_state_ff <= 1'b0;
        end else begin
            miss_ff <= ev_addr_nack || ev_final_nack ||
                       (miss_ff && !w1c_miss && !ev_stop_done);
            if (ev_addr_nack) ack_state_ff <= 1'b0;
            else if (st_ff == ST_AACK && bit_end) ack_state_ff <= 1'b1;
        end
    end

    // Transmit byte: flushed on stop after a missing acknowledge
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            tx_full_ff <= 1'b0;
            tx_data_ff <= TWMR_DATA_RST;
        end else if (ev_go_stop) begin
            tx_full_ff <= 1'b0;
        end else if (dp_wr_ff && dp_sel_ff == 3'h1 && !slave_rx_busy_in) begin
            tx_full_ff <= 1'b1;
            tx_data_ff <= hwdata_in[7:0];
        end
    end

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);

    a_start_sda_low: assert property ((st_ff == ST_START) && $rose(ph_ff == 2'h3) |-> sda_oe_ff && !scl_oe_ff)
        else $error("start condition not driven");
    a_addr_from_start: assert property ($rose(st_ff == ST_ADDR) && seq_ff != 2'h1 |-> $past(st_ff) == ST_START)
        else $error("address sent without start");
    a_read_dir_bit: assert property ((st_ff == ST_START) && bit_end && (!ten_ff || seq_ff == 2'h2)
        |=> shift_ff[0] == TWMR_DIR_RD)
        else $error("read direction bit missing");
    a_ten_prefix: assert property ((st_ff == ST_START) && bit_end && ten_ff
        |=> shift_ff[7:1] == {TWMR_TEN_PREFIX, saddr_ff[9:8]})
        else $error("ten-bit first byte wrong");
    a_nack_flag: assert property (ev_addr_nack |=> miss_ff && !ack_state_ff && st_ff == ST_HOLD)
        else $error("address nack not flagged");
    a_byte_ack: assert property ((st_ff == ST_MACK) && (ph_ff == 2'h2) |-> sda_oe_ff == !last_ff)
        else $error("wrong acknowledge level");
    a_rx_status: assert property (ev_push |=> fifo_out_valid && st_ff == ST_MACK)
        else $error("received byte not posted");
    a_final_flag: assert property (ev_final_nack |=> miss_ff ##1 st_ff == ST_HOLD)
        else $error("final nack not flagged");
    a_stop_release: assert property (ev_stop_done |=> st_ff == ST_IDLE && !stop_ff && !miss_ff
        ##1 !scl_oe_ff && !sda_oe_ff)
        else $error("lines not released after stop");
    a_flush_tx: assert property (ev_go_stop |=> !tx_full_ff && st_ff == ST_STOP)
        else $error("transmit byte not flushed");
    a_block_write: assert property (dp_wr_ff && dp_sel_ff == 3'h1 && slave_rx_busy_in && !tx_full_ff
        |=> !tx_full_ff)
        else $error("data write not blocked");
endmodule // twmr_core

// *** pkg/twmr_pkg.sv ***
// Package: register map, field positions, reset values, timing and states of the two-wire read master
package twmr_pkg;

    // Register byte offsets (low twelve address bits)
    localparam logic [11:0] TWMR_DATA_OFS  = 12'hF50;   // Received byte / transmit byte
    localparam logic [11:0] TWMR_CTRL_OFS  = 12'hF54;   // Control bits
    localparam logic [11:0] TWMR_STAT_OFS  = 12'hF58;   // Status bits
    localparam logic [11:0] TWMR_SADDR_OFS = 12'hF5C;   // Slave address

    // Control field positions
    localparam int TWMR_CTL_START = 0;   // Start request
    localparam int TWMR_CTL_STOP  = 1;   // Stop request
    localparam int TWMR_CTL_NAK   = 2;   // Negative acknowledge on next byte
    localparam int TWMR_CTL_TXI   = 3;   // Transmit request bit
    localparam int TWMR_CTL_TEN   = 4;   // Ten-bit addressing

    // Status field positions
    localparam int TWMR_STS_MISS  = 0;   // Missing-acknowledge flag, write one to clear
    localparam int TWMR_STS_ACK   = 1;   // Last address acknowledged
    localparam int TWMR_STS_RXAV  = 2;   // Received byte waiting
    localparam int TWMR_STS_BUSY  = 3;   // Sequencer not idle
    localparam int TWMR_STS_TXF   = 4;   // Transmit byte held
    localparam int TWMR_STS_RXF   = 5;   // Receive buffer full

    // Reset values
    localparam logic [7:0] TWMR_DATA_RST  = 8'h00;
    localparam logic [4:0] TWMR_CTRL_RST  = 5'h00;
    localparam logic [9:0] TWMR_SADDR_RST = 10'h000;

    // Address byte constants
    localparam logic [4:0] TWMR_TEN_PREFIX = 5'h1E;   // Fixed head of a ten-bit first byte
    localparam logic       TWMR_DIR_WR     = 1'b0;
    localparam logic       TWMR_DIR_RD     = 1'b1;

    // Timing: quarter of a serial bit period
    localparam int TWMR_CLK_NS = 20;
    localparam int TWMR_QTR_NS = 2500;
    localparam int TWMR_QTR_CYC = (TWMR_QTR_NS + TWMR_CLK_NS - 1) / TWMR_CLK_NS;

    // Sequencer states
    typedef enum logic [3:0] {
        ST_IDLE  = 4'h0,
        ST_START = 4'h1,
        ST_ADDR  = 4'h2,
        ST_AACK  = 4'h3,
        ST_RX    = 4'h4,
        ST_MACK  = 4'h5,
        ST_HOLD  = 4'h6,
        ST_STOP  = 4'h7
    } twmr_state_t;

endpackage

// *** tb/twmr_core_bench.sv ***
// Bench of the two-wire read master over AHB-Lite
module twmr_core_bench import twmr_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk_in = 1'b0, rst_in = 1'b1;   // Clock and reset
    logic [1:0]  htrans;                         // Bus master signals
    logic [31:0] haddr, hwdata, hrdata, q;
    logic        hwrite, hready, rx_busy, scl_oe, sda_oe, s_oe;
    logic [7:0]  first;                          // Slave data seed
    wire         scl_w = ~scl_oe;                // Pulled-up lines
    wire         sda_w = ~(sda_oe | s_oe);
    int          fails, n_tests;
    logic [11:0] ofs [5] = '{TWMR_DATA_OFS, TWMR_CTRL_OFS, TWMR_STAT_OFS, TWMR_SADDR_OFS, 12'hF60}; // Reset reads
    initial forever #10 clk_in = ~clk_in;
    twmr_core #(.QTR_CYCLES(2)) DUT (.clk_in(clk_in), .rst_in(rst_in), .hsel_in(1'b1), .haddr_in(haddr),
        .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata), .hready_in(hready),
        .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(), .slave_rx_busy_in(rx_busy),
        .scl_in(scl_w), .scl_out(), .scl_oe_out(scl_oe), .sda_in(sda_w), .sda_out(), .sda_oe_out(sda_oe));
    twmr_slave #(.ADDR(7'h3A)) slv (.scl_in(scl_w), .sda_in(sda_w), .first_in(first), .sda_oe_out(s_oe));
    // Compare and count
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic summarize();
        $display("Counts: %0d compares, %0d mismatches", n_tests, fails);
        if (fails == 0 && n_tests > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // One single AHB transfer, entered just after an edge; read data lands in q
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        int t;
        t = 0;
        htrans <= 2'h2;
        haddr <= {20'h0, a};
        hwrite <= w;
        do begin @(posedge clk_in); t++; end while (hready !== 1'b1 && t < 99);
        htrans <= 2'h0;
        hwdata <= d;
        do begin @(posedge clk_in); t++; end while (hready !== 1'b1 && t < 99);
        q = hrdata;
        if (t >= 99) begin fails++; summarize(); end
    endtask
    // Poll a status bit, bounded
    task automatic wait_stat(input int b, input logic v);
        int t;
        for (t = 0; t < 500; t++) begin
            bus(1'b0, TWMR_STAT_OFS, 32'h0);
            if (q[b] === v) break;
        end
        if (t >= 500) begin fails++; summarize(); end
    endtask
    // Read n bytes from the model slave, then stop
    task automatic rd_test(input int n);
        first = 8'($urandom);
        bus(1'b1, TWMR_SADDR_OFS, 32'h3A);
        bus(1'b1, TWMR_CTRL_OFS, (n == 1) ? 32'h5 : 32'h1);
        for (int i = 0; i < n; i++) begin
            wait_stat(TWMR_STS_RXAV, 1'b1);
            if (i == n - 2) bus(1'b1, TWMR_CTRL_OFS, 32'h4);
            bus(1'b0, TWMR_DATA_OFS, 32'h0);
            chk("rx byte", q, {24'h0, first + 8'(i) * 8'h35});
        end
        wait_stat(TWMR_STS_MISS, 1'b1);
        bus(1'b1, TWMR_CTRL_OFS, 32'h2);
        wait_stat(TWMR_STS_BUSY, 1'b0);
        chk("miss cleared", q & 32'h1, 32'h0);
        chk("lines released", {30'h0, scl_oe, sda_oe}, 32'h0);
        $display("read of %0d bytes done", n);
    endtask
    initial begin
        htrans = 2'h0; haddr = 32'h0; hwrite = 1'b0; hwdata = 32'h0; rx_busy = 1'b0; first = 8'h00;
        void'($urandom(32'hf8d9726c));
        repeat (12) @(posedge clk_in);
        rst_in <= 1'b0;
        @(posedge clk_in);
        // Reset values, unmapped place reads zero
        foreach (ofs[i]) begin
            bus(1'b0, ofs[i], 32'h0);
            chk("reset value", q, 32'h0);
        end
        $display("reset test done");
        // Data writes blocked during slave receive
        rx_busy <= 1'b1;
        bus(1'b1, TWMR_DATA_OFS, 32'hA5);
        bus(1'b0, TWMR_STAT_OFS, 32'h0);
        chk("tx held blocked", q & 32'h10, 32'h0);
        rx_busy <= 1'b0;
        bus(1'b1, TWMR_DATA_OFS, 32'hA5);
        bus(1'b0, TWMR_STAT_OFS, 32'h0);
        chk("tx held", q & 32'h10, 32'h10);
        // Unanswered address, then recovery
        bus(1'b1, TWMR_SADDR_OFS, 32'h3B);
        bus(1'b1, TWMR_CTRL_OFS, 32'h9);
        wait_stat(TWMR_STS_MISS, 1'b1);
        chk("ack state", q & 32'h2, 32'h0);
        bus(1'b1, TWMR_CTRL_OFS, 32'h2);
        wait_stat(TWMR_STS_BUSY, 1'b0);
        chk("flag and tx flushed", q & 32'h11, 32'h0);
        $display("address nack test done");
        // Ten-bit first byte carries a write bit, so the read-only slave model refuses it
        bus(1'b1, TWMR_SADDR_OFS, 32'h2C5);
        bus(1'b1, TWMR_CTRL_OFS, 32'h11);
        wait_stat(TWMR_STS_MISS, 1'b1);
        chk("ten-bit ack state", q & 32'h2, 32'h0);
        bus(1'b1, TWMR_CTRL_OFS, 32'h2);
        wait_stat(TWMR_STS_BUSY, 1'b0);
        chk("ten-bit flag cleared", q & 32'h1, 32'h0);
        $display("ten-bit nack test done");
        rd_test(1);
        rd_test(2);
        repeat (3) rd_test(1 + int'($urandom % 4));
        summarize();
    end
endmodule // twmr_core_bench

// *** tb/twmr_slave.sv ***
// Two-wire slave model that answers master reads
module twmr_slave #(
    parameter logic [6:0] ADDR = 7'h3A   // Own bus address
) (
    // Bus lines and data seed
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    input  wire logic [7:0] first_in,
    output logic            sda_oe_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] n   = 4'h0;    // Bit count in byte
    logic       act = 1'b0;    // Taking part in a transfer
    logic       rd  = 1'b0;    // Sending data bytes
    logic [7:0] k   = 8'h00;   // Byte index
    logic [7:0] sh  = 8'h00;   // Shift-in of address
    logic [7:0] tx;            // Byte being sent
    assign tx = first_in + k * 8'h35;
    initial sda_oe_out = 1'b0;
    // Start: data falls while clock high
    always @(negedge sda_in) if (scl_in) begin
        n = 4'h0;
        act = 1'b1;
        rd = 1'b0;
    end
    // Sample on clock rise; a master nack ends the read
    always @(posedge scl_in) begin
        if (n < 4'h8) sh = {sh[6:0], sda_in};
        if (n == 4'h8 && rd && sda_in) act = 1'b0;
        n = (n == 4'h8) ? 4'h0 : n + 4'h1;
    end
    // Drive on clock fall; a released line floats high through the pull-up
    always @(negedge scl_in) begin
        if (!act) sda_oe_out = 1'b0;
        else if (n == 4'h8 && !rd) begin
            rd = (sh == {ADDR, 1'b1});
            act = rd;
            sda_oe_out = rd;
            k = 8'h00;
        end else if (rd && n < 4'h8) sda_oe_out = !tx[3'd7 - n[2:0]];
        else begin
            sda_oe_out = 1'b0;
            if (rd) k = k + 8'h01;
        end
    end
endmodule // twmr_slave
